// >>> rtl/mtcs_top.sv
/*
  Transmit configuration, remote disable, backoff sequencing and
  transmit status of a 10 Mbit/s CSMA/CD controller.
  Assumes a serializer that sends a frame while TX_ACTIVE_OUT is high
  and pulses TX_END_IN on the same clock, a receive filter that pulses
  the hash hits, and asynchronous medium and FIFO levels.
*/
// What this block does
// RULE_01 - Append CRC unless inhibit bit set
// RULE_02 - CRC inhibit works in every loopback mode
// RULE_03 - Two-bit field selects normal operation or one of three loopbacks
// RULE_04 - Endec loop pin high only in mode two
// RULE_05 - Host clears normal select when using loopback
// RULE_06 - Loopback field resets to normal operation
// RULE_07 - Hash bit 62 packet disables transmitter
// RULE_08 - Hash bit 63 packet re-enables transmitter
// RULE_09 - Clearing remote disable bit re-enables transmitter
// RULE_10 - Low priority backoff for first three collisions
// RULE_11 - Otherwise standard truncated binary exponential backoff
// RULE_12 - Status cleared when host starts transmission
// RULE_13 - Status bits set only by real events
// RULE_14 - Host reads status after each transmission
// RULE_15 - Sent flag only without abort or underrun
// RULE_16 - Collided flag plus separate collision count
// RULE_17 - Abort when sixteenth attempt collides
// RULE_18 - Carrier loss flagged, transmission continues
// RULE_19 - FIFO starvation flags underrun and aborts
// RULE_20 - Missing heartbeat within gap window flagged
// RULE_21 - Late collision flagged, then rescheduled normally
// RULE_22 - Status undefined before first transmission ends
// RULE_23 - Loopback needs normal select low too
// RULE_24 - Reserved bits read zero, ignored on write
// RULE_25 - Remotely disabled transmitter refuses new starts
`timescale 1ns/1ps
`default_nettype none
module mtcs_top
  import mtcs_pkg::*;
#(
  parameter int SLOT_CYCLES_P = SLOT_CYCLES
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic COLLISION_IN,
  input wire logic CARRIER_IN,
  input wire logic FIFO_EMPTY_IN,
  input wire logic BUS_GRANT_IN,
  input wire logic TX_END_IN,
  input wire logic RX_HASH62_IN,
  input wire logic RX_HASH63_IN,
  output logic TX_ACTIVE_OUT,
  output logic TX_ABORT_OUT,
  output logic CRC_APPEND_OUT,
  output logic [1:0] LOOP_MODE_OUT,
  output logic LOOP_ACTIVE_OUT,
  output logic ENDEC_LOOP_PIN_OUT,
  output logic TX_DISABLED_OUT
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mtcs_state_t state_q;
  logic col_s1_q, col_s2_q, col_s3_q;
  logic crs_s1_q, crs_s2_q, crs_s3_q;
  logic emp_s1_q, emp_s2_q, gnt_s1_q, gnt_s2_q;
  logic crc_append_q, atd_q, low_pri_q, normal_sel_q, remote_dis_q;
  logic loop_active_q, endec_pin_q, tx_active_q, tx_abort_q;
  logic [1:0] loop_mode_q;
  logic [7:0] stat_q, rdata_q;
  logic [4:0] coll_q;
  logic [13:0] elapsed_q, slot_cnt_q;
  logic [10:0] hb_cnt_q;
  logic hb_seen_q, late_q, crs_up_q;
  logic [9:0] bo_slots_q;
  logic [15:0] lfsr_q;
  logic col_rise, crs_fall, send, wr_tcfg, wr_dcfg, start_req, start_ok;
  logic ev_col, ev_abort, ev_under, ev_end, gap_done, slot_tick;
  logic [4:0] coll_nx, bo_exp;
  logic [9:0] bo_mask;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two stages per pin; a third stage feeds only the edge detectors
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      col_s1_q <= 1'b0;
      col_s2_q <= 1'b0;
      col_s3_q <= 1'b0;
      crs_s1_q <= 1'b0;
      crs_s2_q <= 1'b0;
      crs_s3_q <= 1'b0;
      emp_s1_q <= 1'b0;
      emp_s2_q <= 1'b0;
      gnt_s1_q <= 1'b0;
      gnt_s2_q <= 1'b0;
    end else begin
      col_s1_q <= COLLISION_IN;
      col_s2_q <= col_s1_q;
      col_s3_q <= col_s2_q;
      crs_s1_q <= CARRIER_IN;
      crs_s2_q <= crs_s1_q;
      crs_s3_q <= crs_s2_q;
      emp_s1_q <= FIFO_EMPTY_IN;
      emp_s2_q <= emp_s1_q;
      gnt_s1_q <= BUS_GRANT_IN;
      gnt_s2_q <= gnt_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Decode and events
  // ----------------------------------------------------------------
  // Register strobes and per-cycle transmit events
  assign col_rise = col_s2_q & ~col_s3_q;
  assign crs_fall = ~crs_s2_q & crs_s3_q;
  assign send = (state_q == ST_SEND);
  assign wr_tcfg = REG_WR_IN && (REG_ADDR_IN == ADDR_TCFG);
  assign wr_dcfg = REG_WR_IN && (REG_ADDR_IN == ADDR_DCFG);
  assign start_req = REG_WR_IN && (REG_ADDR_IN == ADDR_CMD) && REG_WDATA_IN[CMD_START_BIT];
  assign start_ok = start_req && (state_q == ST_IDLE) && !remote_dis_q; // RULE_25
  assign ev_col = send && col_rise;
  assign ev_abort = ev_col && (coll_nx == MAX_ATTEMPTS); // RULE_17
  assign ev_under = send && emp_s2_q && !gnt_s2_q && !ev_col; // RULE_19
  assign ev_end = send && TX_END_IN && !ev_col && !ev_under;
  assign gap_done = (state_q == ST_GAP) && (hb_cnt_q == 11'h000);
  assign slot_tick = (slot_cnt_q == 14'h0000);

  // Backoff exponent and random slot mask
  always_comb begin
    coll_nx = coll_q + 5'h01;
    if (low_pri_q && (coll_nx <= LP_COLLISIONS)) begin
      bo_exp = coll_nx + LP_EXP_OFFSET; // RULE_10
    end else begin
      bo_exp = coll_nx; // RULE_11
    end
    if (bo_exp > BO_MAX_EXP) begin
      bo_exp = BO_MAX_EXP;
    end
    bo_mask = ~(10'h3FF << bo_exp);
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Write-only transmit and data configuration; upper bits dropped
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      crc_append_q <= CRC_APPEND_RESET;
      loop_mode_q <= LOOP_RESET; // RULE_06
      atd_q <= 1'b0;
      low_pri_q <= 1'b0;
      normal_sel_q <= NORMAL_SEL_RESET;
      loop_active_q <= 1'b0;
      endec_pin_q <= 1'b0;
    end else if (wr_tcfg) begin
      crc_append_q <= ~REG_WDATA_IN[TCFG_CRC_INH_BIT]; // RULE_01 RULE_02 RULE_24
      loop_mode_q <= REG_WDATA_IN[TCFG_LOOP_HI_BIT:TCFG_LOOP_LO_BIT]; // RULE_03
      atd_q <= REG_WDATA_IN[TCFG_ATD_BIT];
      low_pri_q <= REG_WDATA_IN[TCFG_LOW_PRIORITY_BACKOFF_BIT];
      loop_active_q <= (REG_WDATA_IN[TCFG_LOOP_HI_BIT:TCFG_LOOP_LO_BIT] != LOOP_NORMAL) && !normal_sel_q; // RULE_23
      endec_pin_q <= (REG_WDATA_IN[TCFG_LOOP_HI_BIT:TCFG_LOOP_LO_BIT] == LOOP_ENDEC); // RULE_04
    end else if (wr_dcfg) begin
      normal_sel_q <= REG_WDATA_IN[DCFG_NORMAL_BIT];
      loop_active_q <= (loop_mode_q != LOOP_NORMAL) && !REG_WDATA_IN[DCFG_NORMAL_BIT]; // RULE_23 RULE_05
    end
  end

  // ----------------------------------------------------------------
  // Remote transmit disable
  // ----------------------------------------------------------------
  // A disabling packet wins over any re-enable in the same cycle
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      remote_dis_q <= 1'b0;
    end else if (atd_q && RX_HASH62_IN) begin
      remote_dis_q <= 1'b1; // RULE_07
    end else if ((atd_q && RX_HASH63_IN) || (wr_tcfg && !REG_WDATA_IN[TCFG_ATD_BIT])) begin
      remote_dis_q <= 1'b0; // RULE_08 RULE_09
    end
  end

  // ----------------------------------------------------------------
  // Random source
  // ----------------------------------------------------------------
  // Free-running LFSR feeding the backoff slot draw
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lfsr_q <= LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  // Attempts, backoff slots and the heartbeat window after a frame
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_IDLE;
      tx_active_q <= 1'b0;
      tx_abort_q <= 1'b0;
      coll_q <= 5'h00;
      elapsed_q <= 14'h0000;
      slot_cnt_q <= 14'h0000;
      bo_slots_q <= 10'h000;
      hb_cnt_q <= 11'h000;
      hb_seen_q <= 1'b0;
      crs_up_q <= 1'b0;
    end else begin
      tx_abort_q <= 1'b0;
      crs_up_q <= send && (crs_up_q || (crs_s2_q && !crs_s3_q)); // Ignore the previous attempt's carrier drop RULE_13
      case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            state_q <= ST_SEND;
            tx_active_q <= 1'b1;
            coll_q <= 5'h00; // RULE_16
            elapsed_q <= 14'h0000;
          end
        end
        ST_SEND: begin
          if (elapsed_q != 14'h3FFF) begin
            elapsed_q <= elapsed_q + 14'h0001;
          end
          if (ev_col) begin
            coll_q <= coll_nx; // RULE_16
            tx_active_q <= 1'b0;
            if (ev_abort) begin
              state_q <= ST_IDLE; // RULE_17
              tx_abort_q <= 1'b1;
            end else begin
              state_q <= ST_BACKOFF; // RULE_21
              bo_slots_q <= lfsr_q[9:0] & bo_mask;
              slot_cnt_q <= 14'(SLOT_CYCLES_P - 1);
            end
          end else if (ev_under) begin
            state_q <= ST_IDLE; // RULE_19
            tx_active_q <= 1'b0;
            tx_abort_q <= 1'b1;
          end else if (ev_end) begin
            state_q <= ST_GAP;
            tx_active_q <= 1'b0;
            hb_cnt_q <= 11'(HB_CYCLES - 1);
            hb_seen_q <= 1'b0;
          end
        end
        ST_BACKOFF: begin
          if (bo_slots_q == 10'h000) begin
            state_q <= ST_SEND;
            tx_active_q <= 1'b1;
            elapsed_q <= 14'h0000;
          end else if (slot_tick) begin
            bo_slots_q <= bo_slots_q - 10'h001;
            slot_cnt_q <= 14'(SLOT_CYCLES_P - 1);
          end else begin
            slot_cnt_q <= slot_cnt_q - 14'h0001;
          end
        end
        ST_GAP: begin
          if (col_s2_q) begin
            hb_seen_q <= 1'b1; // RULE_20
          end
          if (gap_done) begin
            state_q <= ST_IDLE;
          end else begin
            hb_cnt_q <= hb_cnt_q - 11'h001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          tx_active_q <= 1'b0;
        end
      endcase
    end
  end

  // Late-collision marker for the current attempt
  assign late_q = (elapsed_q >= 14'(SLOT_CYCLES_P)); // RULE_21

  // ----------------------------------------------------------------
  // Transmit status
  // ----------------------------------------------------------------
  // Cleared at each accepted start; bits only ever set by events
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      stat_q <= STATUS_RESET; // RULE_22
    end else if (start_ok) begin
      stat_q <= STATUS_RESET; // RULE_12
    end else begin
      if (ev_col) begin
        stat_q[ST_COL_BIT] <= 1'b1; // RULE_16 RULE_13
      end
      if (ev_col && late_q) begin
        stat_q[ST_OWC_BIT] <= 1'b1; // RULE_21
      end
      if (ev_abort) begin
        stat_q[ST_ABT_BIT] <= 1'b1; // RULE_17
      end
      if (send && crs_up_q && crs_fall) begin
        stat_q[ST_CRS_BIT] <= 1'b1; // RULE_18
      end
      if (ev_under) begin
        stat_q[ST_FU_BIT] <= 1'b1; // RULE_19
      end
      if (gap_done && !hb_seen_q && !col_s2_q) begin
        stat_q[ST_CDH_BIT] <= 1'b1; // RULE_20
      end
      if (gap_done && !stat_q[ST_ABT_BIT] && !stat_q[ST_FU_BIT]) begin
        stat_q[ST_PTX_BIT] <= 1'b1; // RULE_15
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Data one cycle after the read strobe, zero otherwise
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= 8'h00;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        ADDR_STATUS: rdata_q <= stat_q; // RULE_24
        ADDR_RETRY: rdata_q <= {3'h0, coll_q}; // RULE_16
        ADDR_CMD: rdata_q <= {6'h00, remote_dis_q, (state_q != ST_IDLE)};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA_OUT = rdata_q;
  assign TX_ACTIVE_OUT = tx_active_q;
  assign TX_ABORT_OUT = tx_abort_q;
  assign CRC_APPEND_OUT = crc_append_q;
  assign LOOP_MODE_OUT = loop_mode_q;
  assign LOOP_ACTIVE_OUT = loop_active_q;
  assign ENDEC_LOOP_PIN_OUT = endec_pin_q;
  assign TX_DISABLED_OUT = remote_dis_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_tcfg_write;
    wr_tcfg ##1 1'b1;
  endsequence

  sequence seq_started;
    start_ok ##1 (state_q == ST_SEND);
  endsequence

  AST_CRC_APPEND: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_01
    wr_tcfg |=> (CRC_APPEND_OUT == !$past(REG_WDATA_IN[TCFG_CRC_INH_BIT])))
    else $error("CRC append does not follow inhibit bit");
  AST_ENDEC_PIN: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_04
    ENDEC_LOOP_PIN_OUT == (LOOP_MODE_OUT == LOOP_ENDEC))
    else $error("Endec loop pin disagrees with loop mode");
  AST_LOOP_NEEDS_SEL: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_23
    seq_tcfg_write |-> (LOOP_ACTIVE_OUT == ((LOOP_MODE_OUT != LOOP_NORMAL) && !normal_sel_q)))
    else $error("Loop active wrong after config write");
  AST_REMOTE_OFF: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_07
    (atd_q && RX_HASH62_IN) |=> TX_DISABLED_OUT)
    else $error("Hash 62 packet did not disable transmitter");
  AST_REMOTE_ON: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_08
    (atd_q && RX_HASH63_IN && !RX_HASH62_IN) |=> !TX_DISABLED_OUT)
    else $error("Hash 63 packet did not re-enable transmitter");
  AST_REFUSE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_25
    (start_req && TX_DISABLED_OUT && (state_q == ST_IDLE)) |=> (state_q == ST_IDLE) && !TX_ACTIVE_OUT)
    else $error("Disabled transmitter accepted a start");
  AST_STATUS_CLEAR: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_12
    seq_started |-> (stat_q == 8'h00) && TX_ACTIVE_OUT)
    else $error("Status not cleared at start");
  AST_ABORT: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_17
    (send && col_rise && (coll_q == 5'h0F)) |=> stat_q[ST_ABT_BIT] && TX_ABORT_OUT && (state_q == ST_IDLE))
    else $error("Sixteenth collision did not abort");
  AST_SENT_OK: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_15
    $rose(stat_q[ST_PTX_BIT]) |-> !stat_q[ST_ABT_BIT] && !stat_q[ST_FU_BIT] && $past(state_q == ST_GAP))
    else $error("Sent flag set after abort or underrun");
  AST_CARRIER_GOES_ON: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_18
    (send && crs_up_q && crs_fall && !col_rise && !ev_under && !TX_END_IN) |=> stat_q[ST_CRS_BIT] && TX_ACTIVE_OUT)
    else $error("Carrier loss aborted or not flagged");
  AST_BACKOFF_LOW: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_10
    (ev_col && low_pri_q && coll_q < LP_COLLISIONS) |=> bo_slots_q < (10'h001 << (coll_q + LP_EXP_OFFSET)))
    else $error("Low priority backoff draw out of range");
  AST_BACKOFF_STD: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN) // RULE_11
    (ev_col && !ev_abort && !low_pri_q) |=> (coll_q >= BO_MAX_EXP || bo_slots_q < (10'h001 << coll_q)))
    else $error("Standard backoff draw out of range");
endmodule
`default_nettype wire

// >>> rtl/mtcs_pkg.sv
/*
  Constants, register map and state type of the transmit configuration
  and status block. Assumes a 200 MHz single clock.
*/
`default_nettype none
package mtcs_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RETRY = 4'h5;
  localparam logic [3:0] ADDR_TCFG = 4'hD;
  localparam logic [3:0] ADDR_DCFG = 4'hE;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_START_BIT = 0;
  localparam int CMD_BUSY_BIT = 0;
  localparam int CMD_DISABLED_BIT = 1;
  localparam int TCFG_CRC_INH_BIT = 0;
  localparam int TCFG_LOOP_LO_BIT = 1;
  localparam int TCFG_LOOP_HI_BIT = 2;
  localparam int TCFG_ATD_BIT = 3;
  localparam int TCFG_LOW_PRIORITY_BACKOFF_BIT = 4;
  localparam int DCFG_NORMAL_BIT = 3;
  localparam int ST_PTX_BIT = 0;
  localparam int ST_COL_BIT = 2;
  localparam int ST_ABT_BIT = 3;
  localparam int ST_CRS_BIT = 4;
  localparam int ST_FU_BIT = 5;
  localparam int ST_CDH_BIT = 6;
  localparam int ST_OWC_BIT = 7;
  localparam logic [1:0] LOOP_NORMAL = 2'h0;
  localparam logic [1:0] LOOP_ENDEC = 2'h2;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] LOOP_RESET = 2'h0;
  localparam logic CRC_APPEND_RESET = 1'b1;
  localparam logic NORMAL_SEL_RESET = 1'b1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SLOT_TIME_NS = 51200;
  localparam int HB_WINDOW_NS = 6400;
  localparam int SLOT_CYCLES = SLOT_TIME_NS * CLK_MHZ / 1000;
  localparam int HB_CYCLES = HB_WINDOW_NS * CLK_MHZ / 1000;
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [4:0] BO_MAX_EXP = 5'h0A;
  localparam logic [4:0] LP_EXP_OFFSET = 5'h03;
  localparam logic [4:0] LP_COLLISIONS = 5'h03;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEND = 4'h2,
    ST_BACKOFF = 4'h4,
    ST_GAP = 4'h8
  } mtcs_state_t;
endpackage
`default_nettype wire

// >>> test/mtcs_medium.sv
/*
  Far side of the transmit path: serializer, medium and FIFO levels.
  Assumes the bench sets the fault knobs before each start command.
*/
`timescale 1ns/1ps
`default_nettype none
module mtcs_medium (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_active,
  input wire logic clr,
  input wire logic hb_en,
  input wire logic starve,
  input wire logic crs_drop,
  input wire logic [4:0] col_n,
  input wire logic [5:0] col_at,
  input wire logic [5:0] len,
  output logic tx_end,
  output logic collision,
  output logic carrier,
  output logic fifo_empty,
  output logic bus_grant
);
  logic [5:0] cnt;
  logic [4:0] made;
  logic [3:0] gap;
  logic act_q;
  logic ended;
  // ----------------------------------------------------------------
  // Frame, collision and heartbeat behaviour
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 6'h00;
      made <= 5'h00;
      gap <= 4'hF;
      act_q <= 1'b0;
      ended <= 1'b0;
      tx_end <= 1'b0;
      collision <= 1'b0;
      carrier <= 1'b0;
      fifo_empty <= 1'b0;
      bus_grant <= 1'b1;
    end else begin
      act_q <= tx_active;
      tx_end <= 1'b0;
      carrier <= tx_active && !(crs_drop && cnt >= 6'h08);
      fifo_empty <= starve && tx_active;
      bus_grant <= !(starve && tx_active);
      if (clr) begin
        made <= 5'h00;
      end
      if (tx_active) begin
        cnt <= cnt + 6'h01;
        gap <= 4'h0;
        if (!act_q) ended <= 1'b0;
        if (made < col_n && cnt >= col_at) begin
          collision <= 1'b1;
        end else if (!collision && cnt == len) begin
          tx_end <= 1'b1;
          ended <= 1'b1;
        end
      end else begin
        cnt <= 6'h00;
        if (act_q && collision) begin
          made <= made + 5'h01;
        end
        if (gap != 4'hF) begin
          gap <= gap + 4'h1;
        end
        // Heartbeat burst early in the gap after a finished frame
        collision <= hb_en && ended && gap >= 4'hA && gap < 4'hE;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/mtcs_top_tb_top.sv
/*
  Self-checking bench of the transmit configuration and status block.
  Assumes the medium model beside it and a shortened slot time.
*/
`timescale 1ns/1ps
`default_nettype none
module mtcs_top_tb_top;
  import mtcs_pkg::*;
  localparam int SLOT_P = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, mark = 1'b0, mp = 1'b0, h62 = 1'b0, h63 = 1'b0;
  logic hb_en = 1'b1, starve = 1'b0, crs_drop = 1'b0;
  logic [4:0] col_n = 5'h00;
  logic [5:0] col_at = 6'h00, len = 6'h28;
  logic [7:0] v;
  logic [7:0] expq[$];
  wire logic [7:0] rdata;
  wire logic [1:0] lmode;
  wire logic col, carrier_lost_flag, fe, grant, tend, act, gave_up_flag, crc, lact, lpin, dis;
  int n_fail = 0, n_tests = 0, n_abt = 0, seed = 26;
  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;
  mtcs_top #(.SLOT_CYCLES_P(SLOT_P)) i_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .COLLISION_IN(col),
    .CARRIER_IN(carrier_lost_flag), .FIFO_EMPTY_IN(fe), .BUS_GRANT_IN(grant), .TX_END_IN(tend), .RX_HASH62_IN(h62),
    .RX_HASH63_IN(h63), .TX_ACTIVE_OUT(act), .TX_ABORT_OUT(gave_up_flag), .CRC_APPEND_OUT(crc),
    .LOOP_MODE_OUT(lmode), .LOOP_ACTIVE_OUT(lact), .ENDEC_LOOP_PIN_OUT(lpin), .TX_DISABLED_OUT(dis));
  mtcs_medium i_med (.clk(clk), .rst_n(rst_n), .tx_active(act), .clr(wr && addr == ADDR_CMD),
    .hb_en(hb_en), .starve(starve), .crs_drop(crs_drop), .col_n(col_n), .col_at(col_at), .len(len),
    .tx_end(tend), .collision(col), .carrier(carrier_lost_flag), .fifo_empty(fe), .bus_grant(grant));
  // ----------------------------------------------------------------
  // Compare, bus tasks and verdict
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic c);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    mark <= c;
    if (c) expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    mark <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic pulse(input logic hi);
    @(posedge clk);
    if (hi) h63 <= 1'b1;
    else h62 <= 1'b1;
    @(posedge clk);
    h62 <= 1'b0;
    h63 <= 1'b0;
    @(negedge clk);
  endtask
  task automatic run(input logic [4:0] n, input logic [5:0] at, input logic hb, input logic sv,
                     input logic cd, input logic [7:0] st, input logic [7:0] nc);
    @(posedge clk);
    col_n <= n;
    col_at <= at;
    hb_en <= hb;
    starve <= sv;
    crs_drop <= cd;
    len <= 6'h28 + 6'($random(seed) & 15);
    wreg(ADDR_CMD, 8'h01);
    rreg(ADDR_STATUS, 8'h00, 1'b1);
    for (int i = 0; i < 60000; i++) begin
      rreg(ADDR_CMD, 8'h00, 1'b0);
      if (v[0] === 1'b0) break;
    end
    rreg(ADDR_STATUS, st, 1'b1);
    rreg(ADDR_RETRY, nc, 1'b1);
  endtask
  task automatic test_done;
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Read data checked one cycle after each marked read strobe
  always @(negedge clk) begin
    if (mp) check(rdata, expq.pop_front());
    mp = rd & mark;
  end
  // Abort pulses are one cycle long, so cycles equal pulses
  always @(posedge clk) begin
    if (gave_up_flag === 1'b1) n_abt++;
  end
  // Cut a hang short
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    test_done;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] lp;
    logic ns;
    logic ci;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(8'(lmode), 8'h00);
    check(8'({lpin, lact, dis, crc}), 8'h01);
    for (int i = 0; i < 8; i++) begin
      lp = 2'(i);
      ns = i[2];
      ci = 1'($random(seed));
      wreg(ADDR_DCFG, {4'h0, ns, 3'h0});
      wreg(ADDR_TCFG, {3'h7, 2'h0, lp, ci});
      @(negedge clk);
      check(8'(lmode), 8'(lp));
      check(8'(lpin), 8'(lp == LOOP_ENDEC));
      check(8'(crc), 8'(!ci));
      check(8'(lact), 8'(lp != LOOP_NORMAL && !ns));
    end
    rreg(4'h3, 8'h00, 1'b1);
    wreg(ADDR_DCFG, 8'h08);
    wreg(ADDR_TCFG, {3'h0, 1'($random(seed)), 4'h0});
    run(5'h00, 6'h00, 1'b1, 1'b0, 1'b0, 8'h01, 8'h00);
    run(5'h00, 6'h00, 1'b0, 1'b0, 1'b0, 8'h41, 8'h00);
    run(5'h01, 6'h00, 1'b1, 1'b0, 1'b0, 8'h05, 8'h01);
    run(5'h01, 6'h1E, 1'b1, 1'b0, 1'b0, 8'h85, 8'h01);
    run(5'h00, 6'h00, 1'b1, 1'b0, 1'b1, 8'h11, 8'h00);
    run(5'h10, 6'h00, 1'b1, 1'b0, 1'b0, 8'h0C, 8'h10);
    run(5'h00, 6'h00, 1'b1, 1'b1, 1'b0, 8'h20, 8'h00);
    check(8'(n_abt), 8'h02);
    // Remote disable and the two ways back
    wreg(ADDR_TCFG, 8'h00);
    pulse(1'b0);
    check(8'(dis), 8'h00);
    wreg(ADDR_TCFG, 8'h08);
    pulse(1'b0);
    check(8'(dis), 8'h01);
    wreg(ADDR_CMD, 8'h01);
    repeat (6) @(negedge clk);
    check(8'(act), 8'h00);
    rreg(ADDR_CMD, 8'h02, 1'b1);
    pulse(1'b1);
    check(8'(dis), 8'h00);
    pulse(1'b0);
    wreg(ADDR_TCFG, 8'h00);
    @(negedge clk);
    check(8'(dis), 8'h00);
    test_done;
  end
endmodule
`default_nettype wire
